// ---- inc/mcf_pkg.sv ----
// Shared constants, types and helpers of the main clock frequency meter.
// Assumes one 25 MHz main clock domain; the slow clock is sampled as a pin.
package mcf_pkg;

  // Register byte addresses on the plain register port
  localparam logic [31:0] MCF_ADDR_SYS_CLK_STATUS = 32'h400e0408;
  localparam logic [31:0] MCF_ADDR_MAIN_CLK_FREQ = 32'h400e0424;
  localparam logic [31:0] MCF_ADDR_IRQ_STATUS = 32'h400e04f0;
  localparam logic [31:0] MCF_ADDR_IRQ_MASK = 32'h400e04f4;

  // Field layout
  localparam int MCF_COUNT_W = 16;        // Width of main_cycle_count
  localparam int MCF_VALID_BIT = 16;      // count_valid_flag position
  localparam int MCF_RESTART_BIT = 20;    // measure_restart position
  localparam int MCF_PCK_N = 3;           // Programmable clock outputs
  localparam int MCF_PCK_LSB = 8;         // First prog_clock_out_status bit
  localparam int MCF_IRQ_W = 2;           // Interrupt status width
  localparam int MCF_IRQ_DONE = 0;        // Measurement finished event
  localparam int MCF_IRQ_WPV = 1;         // Write refused by protection
  localparam int MCF_EDGE_W = 5;          // Slow edge counter width

  // Counts
  localparam logic [MCF_EDGE_W-1:0] MCF_SLOW_PERIODS = 5'h10;  // Window length

  // Values after reset
  localparam logic [MCF_COUNT_W-1:0] MCF_COUNT_RST = 16'h0000;
  localparam logic [MCF_IRQ_W-1:0] MCF_IRQ_RST = 2'h0;
  localparam logic [31:0] MCF_RDATA_RST = 32'h0000_0000;

  // Measurement sequencer states
  typedef enum logic [1:0] {
    MCF_ST_IDLE,       // Oscillator off, nothing measured
    MCF_ST_WAIT_EDGE,  // Waiting for the slow edge opening the window
    MCF_ST_COUNT,      // Window open, main cycles being counted
    MCF_ST_DONE        // Result held until restart or oscillator off
  } mcf_state_e;

  // Frequency result as it sits in the register
  typedef struct packed {
    logic valid;                     // count_valid_flag
    logic [MCF_COUNT_W-1:0] count;   // main_cycle_count
  } mcf_freq_s;

  // State of the slow clock synchroniser
  typedef struct packed {
    logic meta;   // First stage, read only by the second
    logic sync;   // Second stage
    logic prev;   // Delayed copy for edge detection
  } mcf_sync_s;

  // State of the window counter
  typedef struct packed {
    logic [MCF_COUNT_W-1:0] cycles;  // Main cycles inside the window
    logic [MCF_EDGE_W-1:0] edges;    // Slow edges seen inside the window
  } mcf_win_s;

  // State of the top module
  typedef struct packed {
    mcf_state_e state;                 // Sequencer state
    mcf_freq_s freq;                   // Published result
    logic [MCF_IRQ_W-1:0] irq_status;  // Sticky events
    logic [MCF_IRQ_W-1:0] irq_mask;    // Interrupt enables
    logic [31:0] rdata;                // Registered read data
  } mcf_main_s;

  // Saturating increment so an absurd clock never wraps to a small count
  function automatic logic [MCF_COUNT_W-1:0] mcf_sat_inc(
    input logic [MCF_COUNT_W-1:0] v
  );
    mcf_sat_inc = (&v) ? v : v + 16'h0001;
  endfunction : mcf_sat_inc

endpackage : mcf_pkg

// ---- rtl/mcf_slow_sync.sv ----
// Two-stage synchroniser and rising edge detector for the slow clock.
// Assumes the slow clock is much slower than the main clock.
`timescale 1ns/1ns
module mcf_slow_sync
  import mcf_pkg::*;
(
  input wire logic i_ref_clk,   // Main clock
  input wire logic i_resetn,    // Synchronous reset, active low
  input wire logic i_ce,        // Clock enable, freezes state when low
  input wire logic i_slow_clk,  // Slow clock, asynchronous
  output logic o_slow_rise      // One-cycle pulse per slow rising edge
);

  mcf_sync_s r_reg;   // Registered state
  mcf_sync_s r_next;  // Next state

  // Shift the pin through two stages, then keep one more for the edge
  always_comb begin
    r_next = r_reg;
    r_next.meta = i_slow_clk;
    r_next.sync = r_reg.meta;
    r_next.prev = r_reg.sync;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // Edge taken from stable stages only, never the first one
  assign o_slow_rise = i_ce & r_reg.sync & ~r_reg.prev;

endmodule : mcf_slow_sync

// ---- rtl/mcf_window_cnt.sv ----
// Counts main clock cycles and slow edges while a window is open.
// Assumes the caller clears it at the edge that opens each window.
`timescale 1ns/1ns
module mcf_window_cnt
  import mcf_pkg::*;
(
  input wire logic i_ref_clk,                 // Main clock
  input wire logic i_resetn,                  // Synchronous reset, active low
  input wire logic i_ce,                      // Clock enable
  input wire logic i_clear,                   // Restart both counts from zero
  input wire logic i_count_en,                // Window open
  input wire logic i_slow_rise,               // Synchronised slow edge
  output logic [MCF_COUNT_W-1:0] o_cycles,    // Cycles counted so far
  output logic [MCF_EDGE_W-1:0] o_edges       // Slow edges counted so far
);

  mcf_win_s r_reg;   // Registered state
  mcf_win_s r_next;  // Next state

  // Clear has priority so a new window never inherits old cycles
  always_comb begin
    r_next = r_reg;
    if (i_clear) begin
      r_next = '0;
    end else if (i_count_en) begin
      r_next.cycles = mcf_sat_inc(r_reg.cycles);
      if (i_slow_rise) begin
        r_next.edges = r_reg.edges + 5'h01;
      end
    end
  end

  // State register
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_reg <= '0;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  assign o_cycles = r_reg.cycles;
  assign o_edges = r_reg.edges;

endmodule : mcf_window_cnt

// ---- rtl/mcf_freq_meter.sv ----
// Main clock frequency meter with system clock status and interrupts.
// Assumes a plain register port on the main clock and a slow clock pin;
// oscillator enable, write protection and clock output enables come
// from logic on the main clock and are read without synchronisers.
`timescale 1ns/1ns

// Overview of operation
// RL1 - Count main cycles over sixteen slow periods
// RL2 - Ready flag low when invalid, off, restarted
// RL3 - Ready flag high after enable and result
// RL4 - Writing one restarts; zero does nothing
// RL5 - Load result exactly as ready rises
// RL6 - Measure whatever source drives main clock
// RL7 - Ignore frequency writes while write-protected
// RL8 - Software reads ready, then reads again
// RL9 - Status bits eight to ten show outputs
// RL10 - Synchronise slow edges, clear counter at start
module mcf_freq_meter
  import mcf_pkg::*;
(
  input wire logic i_ref_clk,                     // Main clock, 25 MHz
  input wire logic i_resetn,                      // Synchronous reset, low
  input wire logic i_ce,                          // Clock enable
  input wire logic i_slow_clk,                    // Slow clock pin
  input wire logic i_main_osc_en,                 // Main oscillator enabled
  input wire logic i_write_protect_en,            // write_protect_enable
  input wire logic [MCF_PCK_N-1:0] i_prog_clk_en, // Clock output enables
  input wire logic [31:0] i_addr,                 // Register byte address
  input wire logic [31:0] i_wdata,                // Write data
  input wire logic i_wr,                          // Write strobe
  input wire logic i_rd,                          // Read strobe
  output logic [31:0] o_rdata,                    // Read data, next cycle
  output logic o_irq,                             // Level interrupt
  output logic o_count_valid_flag,                // Result valid
  output logic [MCF_COUNT_W-1:0] o_main_cycle_count // Latest result
);

  mcf_main_s r_reg;   // Registered state
  mcf_main_s r_next;  // Next state

  logic slow_rise;                    // Synchronised slow edge pulse
  logic [MCF_COUNT_W-1:0] win_cycles; // Cycles in the open window
  logic [MCF_EDGE_W-1:0] win_edges;   // Slow edges in the open window
  logic win_clear;                    // Clear the window counter
  logic win_en;                       // Window open

  // Register port decode
  logic hit_sys;      // System clock status selected
  logic hit_freq;     // Frequency register selected
  logic hit_istat;    // Interrupt status selected
  logic hit_imask;    // Interrupt mask selected
  logic restart_req;  // Accepted restart write
  logic wp_refused;   // Frequency write refused by protection
  logic last_edge;    // This slow edge closes the window

  // Address compare, shared by every register
  function automatic logic addr_is(
    input logic [31:0] a,
    input logic [31:0] b
  );
    addr_is = (a == b);
  endfunction : addr_is

  // Read value of the frequency register; the restart bit reads zero
  function automatic logic [31:0] freq_word(input mcf_freq_s f);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[MCF_COUNT_W-1:0] = f.count;
    w[MCF_VALID_BIT] = f.valid;
    freq_word = w;
  endfunction : freq_word

  // Slow clock crosses through two flops before any logic sees it
  mcf_slow_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_slow_clk(i_slow_clk),
    .o_slow_rise(slow_rise)    // [RL10]
  );

  // Cycle and edge counting for the measurement window
  mcf_window_cnt u_win (
    .i_ref_clk(i_ref_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_clear(win_clear),
    .i_count_en(win_en),
    .i_slow_rise(slow_rise),
    .o_cycles(win_cycles),
    .o_edges(win_edges)
  );

  // Decode of the current access
  always_comb begin
    hit_sys = addr_is(i_addr, MCF_ADDR_SYS_CLK_STATUS);
    hit_freq = addr_is(i_addr, MCF_ADDR_MAIN_CLK_FREQ);
    hit_istat = addr_is(i_addr, MCF_ADDR_IRQ_STATUS);
    hit_imask = addr_is(i_addr, MCF_ADDR_IRQ_MASK);
    // Only a one in the restart bit counts; a zero is harmless
    restart_req = i_wr & hit_freq & i_wdata[MCF_RESTART_BIT]  // [RL4]
                  & ~i_write_protect_en;                        // [RL7]
    // Any write to the frequency register while locked is dropped
    wp_refused = i_wr & hit_freq & i_write_protect_en;          // [RL7]
  end

  // Window control derived from the sequencer state
  always_comb begin
    // Counter restarts at the edge that opens the window
    win_clear = (r_reg.state == MCF_ST_WAIT_EDGE) & slow_rise;  // [RL10]
    win_en = (r_reg.state == MCF_ST_COUNT);
    // The sixteenth edge after the opening edge ends the window
    last_edge = win_en & slow_rise
                & (win_edges == MCF_SLOW_PERIODS - 5'h01);      // [RL1]
  end

  // Sequencer, result register, interrupts and register port
  always_comb begin
    r_next = r_reg;
    // Read data stand for exactly one cycle after a read
    r_next.rdata = MCF_RDATA_RST;

    // Measurement sequencer
    case (r_reg.state)
      MCF_ST_IDLE: begin
        // A running oscillator starts a measurement by itself
        if (i_main_osc_en) begin
          r_next.state = MCF_ST_WAIT_EDGE;
        end
      end
      MCF_ST_WAIT_EDGE: begin
        // Align the window to a slow edge so its length is exact
        if (slow_rise) begin
          r_next.state = MCF_ST_COUNT;                           // [RL1]
        end
      end
      MCF_ST_COUNT: begin
        // Whatever source drives the main clock is what gets counted
        if (last_edge) begin
          r_next.state = MCF_ST_DONE;                            // [RL6]
          // Result and flag change together, so a reader never
          // sees the flag high over a stale count
          r_next.freq.count = mcf_sat_inc(win_cycles);          // [RL5]
          r_next.freq.valid = 1'b1;                              // [RL3]
          r_next.irq_status[MCF_IRQ_DONE] = 1'b1;
        end
      end
      MCF_ST_DONE: begin
        // Hold the result; it changes only through a new window
        r_next.state = MCF_ST_DONE;
      end
      default: begin
        r_next.state = MCF_ST_IDLE;
      end
    endcase

    // Restart throws the old result away and waits for a new window;
    // it wins over a window closing in the same cycle
    if (restart_req) begin
      r_next.state = MCF_ST_WAIT_EDGE;                           // [RL4]
      r_next.freq.valid = 1'b0;                                  // [RL2]
      if (last_edge) begin
        r_next.irq_status[MCF_IRQ_DONE] = r_reg.irq_status[MCF_IRQ_DONE];
        // The count may only move together with a rising flag
        r_next.freq.count = r_reg.freq.count;                    // [RL5]
      end
    end

    // A stopped oscillator drops the result flag and idles the sequencer, above all else
    if (!i_main_osc_en) begin
      r_next.state = MCF_ST_IDLE;
      r_next.freq.valid = 1'b0;                                  // [RL2]
      r_next.irq_status[MCF_IRQ_DONE] = r_reg.irq_status[MCF_IRQ_DONE];
      // A window closing as the oscillator stops is thrown away whole
      r_next.freq.count = r_reg.freq.count;                      // [RL5]
    end

    // Software write to the interrupt mask; the frequency register takes only the restart bit
    if (i_wr && hit_imask) begin
      r_next.irq_mask = i_wdata[MCF_IRQ_W-1:0];
    end

    // Registered read data; unmapped addresses read zero
    if (i_rd) begin
      if (hit_sys) begin
        // One bit per programmable clock output, high when enabled
        r_next.rdata[MCF_PCK_LSB +: MCF_PCK_N] = i_prog_clk_en;  // [RL9]
      end else if (hit_freq) begin
        r_next.rdata = freq_word(r_reg.freq);
      end else if (hit_istat) begin
        r_next.rdata[MCF_IRQ_W-1:0] = r_reg.irq_status;
      end else if (hit_imask) begin
        r_next.rdata[MCF_IRQ_W-1:0] = r_reg.irq_mask;
      end
    end

    // Reading the status clears it; events of this cycle survive
    if (i_rd && hit_istat) begin
      r_next.irq_status = r_next.irq_status & ~r_reg.irq_status;
      if (r_next.state == MCF_ST_DONE && r_reg.state == MCF_ST_COUNT) begin
        r_next.irq_status[MCF_IRQ_DONE] = 1'b1;
      end
    end

    // Refused writes are recorded so software can find the lockout
    if (wp_refused) begin
      r_next.irq_status[MCF_IRQ_WPV] = 1'b1;                     // [RL7]
    end
  end

  // State register; the whole block holds still while i_ce is low
  always_ff @(posedge i_ref_clk) begin
    if (!i_resetn) begin
      r_reg.state <= MCF_ST_IDLE;
      r_reg.freq.valid <= 1'b0;
      r_reg.freq.count <= MCF_COUNT_RST;
      r_reg.irq_status <= MCF_IRQ_RST;
      r_reg.irq_mask <= MCF_IRQ_RST;
      r_reg.rdata <= MCF_RDATA_RST;
    end else if (i_ce) begin
      r_reg <= r_next;
    end
  end

  // Outputs come straight from the state register
  assign o_rdata = r_reg.rdata;
  assign o_irq = |(r_reg.irq_status & r_reg.irq_mask);
  assign o_count_valid_flag = r_reg.freq.valid;                   // [RL2]
  assign o_main_cycle_count = r_reg.freq.count;                   // [RL8]

endmodule : mcf_freq_meter

// ---- sim/mcf_freq_meter_monitor.sv ----
// Checker for the meter's register port, result flag and count.
// Assumes one main clock domain; it sees only the top module ports.
`timescale 1ns/1ns
module mcf_freq_meter_chk
  import mcf_pkg::*;
(
  input wire logic i_ref_clk,                       // Main clock
  input wire logic i_resetn,                        // Reset, active low
  input wire logic i_ce,                            // Clock enable
  input wire logic i_main_osc_en,                   // Oscillator on
  input wire logic i_write_protect_en,              // Write protection
  input wire logic [MCF_PCK_N-1:0] i_prog_clk_en,   // Output enables
  input wire logic [31:0] i_addr,                   // Address
  input wire logic [31:0] i_wdata,                  // Write data
  input wire logic i_wr,                            // Write strobe
  input wire logic i_rd,                            // Read strobe
  input wire logic [31:0] o_rdata,                  // Read data
  input wire logic o_irq,                           // Interrupt
  input wire logic o_count_valid_flag,              // Result valid
  input wire logic [MCF_COUNT_W-1:0] o_main_cycle_count // Result
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_resetn);
  // Write to the frequency register while i_ce is high, protected or not
  wire logic f_wr = i_ce && i_wr && (i_addr == MCF_ADDR_MAIN_CLK_FREQ);
  // Read data must not linger, or software sees stale words
  a_rdata_idle: assert property (i_ce && !i_rd |=> o_rdata == 32'h0)
    else $error("read data not zero after idle cycle");
  a_status_bits: assert property (i_ce && i_rd && i_addr == MCF_ADDR_SYS_CLK_STATUS
    |=> o_rdata == {21'h0, $past(i_prog_clk_en), 8'h0}) else $error("status bits wrong");
  a_freq_view: assert property (i_ce && i_rd && i_addr == MCF_ADDR_MAIN_CLK_FREQ |=>
    o_rdata == {15'h0, $past(o_count_valid_flag), $past(o_main_cycle_count)})
    else $error("frequency word wrong");
  a_restart_drop: assert property (f_wr && i_wdata[20] && !i_write_protect_en
    |=> !o_count_valid_flag) else $error("restart left flag high");
  a_zero_no_effect: assert property (f_wr && !i_wdata[20] && o_count_valid_flag
    && i_main_osc_en |=> o_count_valid_flag) else $error("zero write dropped flag");
  a_protect_hold: assert property (f_wr && i_write_protect_en && o_count_valid_flag
    && i_main_osc_en |=> o_count_valid_flag) else $error("protected write acted");
  a_osc_off_flag: assert property (i_ce && !i_main_osc_en |=> !o_count_valid_flag)
    else $error("flag high with oscillator off");
  a_count_held: assert property (o_count_valid_flag && $past(o_count_valid_flag)
    |-> $stable(o_main_cycle_count)) else $error("count moved while valid");
  a_count_on_rise: assert property (!$stable(o_main_cycle_count)
    |-> $rose(o_count_valid_flag)) else $error("count loaded off flag rise");
  // Main scenarios reached
  c_done: cover property ($rose(o_count_valid_flag));
  c_restart: cover property ($fell(o_count_valid_flag));
  c_refused: cover property (f_wr && i_write_protect_en);
  c_irq: cover property (o_irq);
endmodule : mcf_freq_meter_chk

bind mcf_freq_meter mcf_freq_meter_chk u_chk (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
  .i_ce(i_ce), .i_main_osc_en(i_main_osc_en), .i_write_protect_en(i_write_protect_en),
  .i_prog_clk_en(i_prog_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .o_count_valid_flag(o_count_valid_flag),
  .o_main_cycle_count(o_main_cycle_count));

// ---- sim/tb_top.sv ----
// Self-checking bench for the main clock frequency meter.
// Assumes the checker is bound in from its own file; slow clock made here.
`timescale 1ns/1ns
module tb_top
  import mcf_pkg::*;
;
  logic i_ref_clk = 1'b0; // Main clock, 40 ns
  logic i_resetn, i_ce, i_slow_clk, i_main_osc_en, i_write_protect_en, i_wr, i_rd;
  logic [MCF_PCK_N-1:0] i_prog_clk_en; // Clock output enables
  logic [31:0] i_addr, i_wdata, o_rdata, rnd;
  logic o_irq, o_count_valid_flag;
  logic [MCF_COUNT_W-1:0] o_main_cycle_count;
  logic [31:0] exp_q[$]; // Expected read words, oldest first
  logic rd_seen = 1'b0; // A read was taken at the last edge
  int num_errors = 0;
  int cmp_count = 0;
  int half = 10; // Slow half period in main cycles
  int half_cnt = 0;
  integer seed = 32'hf3ccae63;

  always #20 i_ref_clk = ~i_ref_clk;

  mcf_freq_meter uut (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_ce(i_ce),
    .i_slow_clk(i_slow_clk), .i_main_osc_en(i_main_osc_en),
    .i_write_protect_en(i_write_protect_en), .i_prog_clk_en(i_prog_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_irq(o_irq), .o_count_valid_flag(o_count_valid_flag),
    .o_main_cycle_count(o_main_cycle_count));

  // Slow clock runs free; period stays whole so every window is exact
  always @(posedge i_ref_clk) begin
    if (half_cnt >= half - 1) begin
      i_slow_clk <= ~i_slow_clk;
      half_cnt <= 0;
    end else begin
      half_cnt <= half_cnt + 1;
    end
  end

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // Read data stands only in the cycle after the read, so look there
  always @(posedge i_ref_clk) rd_seen <= i_rd && i_ce;
  always @(negedge i_ref_clk) begin
    if (rd_seen && exp_q.size() > 0) begin
      chk(o_rdata, exp_q.pop_front(), "read data");
    end
  end

  // One-cycle write; the strobe drops one edge later
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle read; the expected word is queued first
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask : rd

  // Bounded wait for a finished window (2000 main cycles at most)
  task automatic wait_valid;
    int n;
    n = 0;
    while (o_count_valid_flag !== 1'b1 && n < 2000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 2000) begin
      num_errors++;
      $display("[ERR] %0t no result", $time);
    end
    @(negedge i_ref_clk);
  endtask : wait_valid

  task results;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : results

  // Hang guard, far above the thousand or so cycles the tests need
  initial begin
    #(40 * 20000);
    num_errors++;
    results();
  end

  initial begin
    {i_resetn, i_slow_clk, i_main_osc_en, i_write_protect_en, i_wr, i_rd} = 6'h0;
    i_ce = 1'b1;
    i_addr = 32'h0;
    i_wdata = 32'h0;
    i_prog_clk_en = 3'h0;
    repeat (10) @(posedge i_ref_clk);
    i_resetn <= 1'b1;
    // Reset view, status mirror, unmapped place, mask access
    rnd = $random(seed);
    i_prog_clk_en <= rnd[2:0];
    rd(MCF_ADDR_MAIN_CLK_FREQ, 32'h0);
    rd(MCF_ADDR_SYS_CLK_STATUS, {21'h0, rnd[2:0], 8'h0});
    rd(32'h400e0500, 32'h0);
    wr(MCF_ADDR_IRQ_MASK, rnd);
    rd(MCF_ADDR_IRQ_MASK, {30'h0, rnd[1:0]});
    wr(MCF_ADDR_IRQ_MASK, 32'h1);
    $display("test reset done");
    // First window after the oscillator comes on: 16 x 20 cycles
    @(posedge i_ref_clk);
    i_main_osc_en <= 1'b1;
    wait_valid();
    chk(o_main_cycle_count, 32'h140, "count");
    rd(MCF_ADDR_MAIN_CLK_FREQ, 32'h0001_0140);
    rd(MCF_ADDR_MAIN_CLK_FREQ, 32'h0001_0140);
    chk(o_irq, 1'b1, "irq raised");
    rd(MCF_ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_irq, 1'b0, "irq cleared");
    $display("test measure done");
    // Zero write ignored, restart with a faster slow clock: 16 x 12
    @(posedge i_ref_clk);
    half <= 6;
    repeat (30) @(posedge i_ref_clk);
    wr(MCF_ADDR_MAIN_CLK_FREQ, 32'hffef_ffff);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b1, "zero write");
    wr(MCF_ADDR_MAIN_CLK_FREQ, 32'h0010_0000);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b0, "restart flag");
    wait_valid();
    chk(o_main_cycle_count, 32'hc0, "new count");
    $display("test restart done");
    // Clock enable low freezes everything, a restart write included
    @(posedge i_ref_clk);
    i_ce <= 1'b0;
    wr(MCF_ADDR_MAIN_CLK_FREQ, 32'h0010_0000);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b1, "frozen restart");
    @(posedge i_ref_clk);
    i_ce <= 1'b1;
    // Protected restart is refused and flagged
    @(posedge i_ref_clk);
    i_write_protect_en <= 1'b1;
    wr(MCF_ADDR_MAIN_CLK_FREQ, 32'h0010_0000);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b1, "protected");
    rd(MCF_ADDR_IRQ_STATUS, 32'h3);
    @(posedge i_ref_clk);
    i_write_protect_en <= 1'b0;
    $display("test protect done");
    // Oscillator off drops the flag; on again measures by itself: 16 x 16
    i_main_osc_en <= 1'b0;
    half <= 8;
    @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b0, "osc off");
    // Let the slow clock settle on its new period before the window
    repeat (20) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
    chk(o_count_valid_flag, 1'b0, "osc still off");
    @(posedge i_ref_clk);
    i_main_osc_en <= 1'b1;
    wait_valid();
    chk(o_main_cycle_count, 32'h100, "remeasure");
    $display("test oscillator done");
    repeat (3) @(posedge i_ref_clk);
    results();
  end
endmodule : tb_top
